// ---- hdl/exec_field_encode.sv ----
// Packs the combined field into status bits 26:25 and 15:10
`timescale 1ns/100ps
module exec_field_encode
	import exec_state_pkg::*;
(
	exec_field_if.encoder fld    // Field contents in, packed bits out
);
	// Resume form zeroes 26:25 and 11:10, block form splits eight bits
	assign fld.bits_hi = (fld.mode == FIELD_ITB) ? fld.itb[1:0] : 2'b00;
	assign fld.bits_lo = (fld.mode == FIELD_ITB)    ? fld.itb[7:2] :
	                     (fld.mode == FIELD_RESUME) ? {fld.resume, 2'b00} : 6'h00;
endmodule : exec_field_encode

// ---- hdl/exec_field_if.sv ----
// Interface carrying the combined field between the state keeper and the encoder
`timescale 1ns/100ps
interface exec_field_if;
	import exec_state_pkg::*;
	field_e      mode;
	logic [7:0]  itb;
	logic [3:0]  resume;
	logic [1:0]  bits_hi;
	logic [5:0]  bits_lo;
	modport keeper  (output mode, output itb, output resume, input bits_hi, input bits_lo);
	modport encoder (input mode, input itb, input resume, output bits_hi, output bits_lo);
endinterface : exec_field_if

// ---- hdl/exec_state_pkg.sv ----
// Constants and types for the execution-state status bits
package exec_state_pkg;
	localparam int          PSW_WIDTH      = 32;
	localparam int          SAT_BIT        = 27;
	localparam int          EXEC_HI_MSB    = 26;
	localparam int          EXEC_HI_LSB    = 25;
	localparam int          STATE_BIT      = 24;
	localparam int          EXEC_LO_MSB    = 15;
	localparam int          EXEC_LO_LSB    = 10;
	localparam int          RESUME_MSB     = 15;
	localparam int          RESUME_LSB     = 12;
	localparam int          ITB_MASK_LSB   = 10;
	localparam logic        STATE_RESET    = 1'b1;
	localparam logic [7:0]  ITB_RESET      = 8'h00;
	localparam logic [3:0]  RESUME_RESET   = 4'h0;
	localparam logic [3:0]  ITB_DONE_MASK  = 4'h8;

	// View selector of a status-register move
	typedef enum logic [1:0] {
		VIEW_FULL  = 2'b00,
		VIEW_EXEC  = 2'b01,
		VIEW_APP   = 2'b10,
		VIEW_OTHER = 2'b11
	} view_e;

	// Which content the combined field holds
	typedef enum logic [1:0] {
		FIELD_IDLE   = 2'b00,
		FIELD_ITB    = 2'b01,
		FIELD_RESUME = 2'b10
	} field_e;
endpackage : exec_state_pkg

// ---- hdl/execution_state_status_bits.sv ----
// Execution-state bits of the program status word
`timescale 1ns/100ps
module execution_state_status_bits
	import exec_state_pkg::*;
(
	input  wire logic        clock_in,            // Core clock, 125 MHz
	input  wire logic        rstn_in,             // Asynchronous reset, active low
	input  wire logic        vector_valid_in,     // Vector fetched at entry or reset
	input  wire logic [31:0] vector_value_in,     // Fetched vector word
	input  wire logic        exch_branch_in,      // Exchange branch or stack load to PC
	input  wire logic [31:0] branch_target_in,    // Target address of that branch
	input  wire logic        exc_return_in,       // Exception return, stacked word valid
	input  wire logic [31:0] stacked_word_in,     // Status word popped from stack
	input  wire logic        itb_start_in,        // If-then instruction executed
	input  wire logic [7:0]  itb_init_in,         // Base condition and slot mask
	input  wire logic        insn_retire_in,      // An instruction completes
	input  wire logic        insn_issue_in,       // An instruction attempts execution
	input  wire logic        xfer_interrupt_in,   // Multi-transfer suspended by interrupt
	input  wire logic [3:0]  xfer_next_reg_in,    // Next register operand index
	input  wire logic        xfer_done_in,        // Resumed transfer finished
	input  wire logic        sat_set_in,          // Saturation event
	input  wire logic        move_write_in,       // Status-register move write
	input  wire logic        move_privileged_in,  // Move comes from privileged code
	input  wire logic [1:0]  move_view_in,        // View targeted by the move
	input  wire logic [31:0] move_wdata_in,       // Move write data
	output logic [31:0]      move_rdata_out,      // Move read data for the view
	output logic [31:0]      stack_word_out,      // Full word for stacking on entry
	output logic             exec_state_out,      // Current instruction set state bit
	output logic             itb_active_out,      // Current instruction is conditional
	output logic [3:0]       itb_cond_out,        // Condition of current block slot
	output logic             xfer_resume_out,     // Resume transfer from index
	output logic [3:0]       xfer_start_reg_out,  // Register to resume at
	output logic             state_fault_out      // Fault: executing with state clear
);
	exec_field_if fld ();

	// View decode shared by the move write and read paths
	function automatic logic view_shows_app(input logic [1:0] view);
		return (view == VIEW_FULL) || (view == VIEW_APP);
	endfunction : view_shows_app

	function automatic logic view_shows_exec(input logic [1:0] view);
		return (view == VIEW_FULL) || (view == VIEW_EXEC);
	endfunction : view_shows_exec

	// Architectural state and its next values
	logic        state_bit;
	logic        sat;
	logic [7:0]  itb;
	logic [3:0]  resume;
	field_e      mode;
	logic        fault;
	logic        next_state_bit;
	logic        next_sat;
	logic [7:0]  next_itb;
	logic [3:0]  next_resume;
	field_e      next_mode;

	// Decode of the incoming requests
	wire         itb_last   = (itb[3:0] == ITB_DONE_MASK);
	wire  [3:0]  itb_shift  = {itb[2:0], 1'b0};
	wire         app_view   = view_shows_app(move_view_in);
	wire         sat_clear  = move_write_in && app_view && !move_wdata_in[SAT_BIT];
	wire         view_exec  = move_privileged_in && view_shows_exec(move_view_in);
	// Block form leaves a nonzero mask in 26:25 or 11:10
	wire         stk_itb    = (stacked_word_in[EXEC_HI_MSB:EXEC_HI_LSB] != 2'b00) ||
	                          (stacked_word_in[11:10] != 2'b00);
	wire  [7:0]  stk_field  = {stacked_word_in[EXEC_LO_MSB:EXEC_LO_LSB],
	                           stacked_word_in[EXEC_HI_MSB:EXEC_HI_LSB]};
	wire  [31:0] full_word;

	// Field contents handed to the encoder
	assign fld.mode   = mode;
	assign fld.itb    = itb;
	assign fld.resume = resume;

	// Encoder packs the field into its status bit positions
	exec_field_encode u_encode (
		.fld (fld.encoder)
	);

	// Full word: reserved bits stay zero
	// Same layout is pushed on entry and popped on return
	assign full_word = {4'h0, sat, fld.bits_hi, state_bit, 8'h00, fld.bits_lo, 10'h000};

	// State bit sources by priority; software writes never reach it
	// Vector fetch outranks return, which outranks a branch
	assign next_state_bit = vector_valid_in ? vector_value_in[0] :
	                        exc_return_in   ? stacked_word_in[STATE_BIT] :
	                        exch_branch_in  ? branch_target_in[0] : state_bit;

	// Set wins over clear; only a move clears it
	// No arithmetic result can clear the flag on its own
	assign next_sat = sat_set_in ? 1'b1 : (sat_clear ? 1'b0 : sat);

	// Combined field sequencing
	always_comb begin
		next_mode   = mode;
		next_itb    = itb;
		next_resume = resume;
		// A vector fetch drops any pending block or transfer
		if (vector_valid_in) begin
			next_mode   = FIELD_IDLE;
			next_itb    = ITB_RESET;
			next_resume = RESUME_RESET;
		end else if (exc_return_in) begin
			// Stacked word decides block form, resume form or neither
			if (stk_itb) begin
				next_mode   = FIELD_ITB;
				next_itb    = stk_field;
				next_resume = RESUME_RESET;
			end else if (stk_field[7:4] != 4'h0) begin
				next_mode   = FIELD_RESUME;
				next_itb    = ITB_RESET;
				next_resume = stacked_word_in[RESUME_MSB:RESUME_LSB];
			end else begin
				next_mode   = FIELD_IDLE;
				next_itb    = ITB_RESET;
				next_resume = RESUME_RESET;
			end
		end else if (xfer_interrupt_in) begin
			next_mode   = FIELD_RESUME;
			next_resume = xfer_next_reg_in;
			next_itb    = ITB_RESET;
		end else if (itb_start_in) begin
			next_mode   = FIELD_ITB;
			next_itb    = itb_init_in;
		end else if (mode == FIELD_ITB && insn_retire_in) begin
			if (itb_last) begin
				next_mode = FIELD_IDLE;
				next_itb  = ITB_RESET;
			end else begin
				// Mask moves up; its top bit becomes the slot inversion
				next_itb  = {itb[7:5], itb[3], itb_shift};
			end
		end else if (mode == FIELD_RESUME && xfer_done_in) begin
			next_mode   = FIELD_IDLE;
			next_resume = RESUME_RESET;
		end
	end

	// Fault is dropped while a vector fetch restores the state bit
	wire         next_fault = insn_issue_in && !state_bit && !vector_valid_in;

	// Instruction set state bit
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_bit <= STATE_RESET;
		end else begin
			state_bit <= next_state_bit;
		end
	end

	// Saturation flag
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sat <= 1'b0;
		end else begin
			sat <= next_sat;
		end
	end

	// Combined field and its content kind
	// Mode says whether the field holds a block or an index
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			itb    <= ITB_RESET;
			resume <= RESUME_RESET;
			mode   <= FIELD_IDLE;
		end else begin
			itb    <= next_itb;
			resume <= next_resume;
			mode   <= next_mode;
		end
	end

	// One-cycle fault pulse
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fault <= 1'b0;
		end else begin
			fault <= next_fault;
		end
	end

	// Move read: exec bits only in full or exec view, privileged
	// Application view carries saturation only
	always_comb begin
		move_rdata_out = 32'h0000_0000;
		if (app_view)
			move_rdata_out[SAT_BIT] = sat;
		if (view_exec) begin
			move_rdata_out[EXEC_HI_MSB:EXEC_HI_LSB] = fld.bits_hi;
			move_rdata_out[STATE_BIT]               = state_bit;
			move_rdata_out[EXEC_LO_MSB:EXEC_LO_LSB] = fld.bits_lo;
		end
	end

	// Outputs decoded from the registers
	assign stack_word_out     = full_word;
	assign exec_state_out     = state_bit;
	assign itb_active_out     = (mode == FIELD_ITB);
	assign itb_cond_out       = {itb[7:5], itb[4]};
	assign xfer_resume_out    = (mode == FIELD_RESUME);
	assign xfer_start_reg_out = resume;
	assign state_fault_out    = fault;
endmodule : execution_state_status_bits

// ---- tb/exec_state_chk.sv ----
// Assertion checker for the execution-state bits
`timescale 1ns/100ps
module exec_state_chk (
	input wire logic        clock_in,
	input wire logic        rstn_in,
	input wire logic        vector_valid_in,
	input wire logic [31:0] vector_value_in,
	input wire logic        exch_branch_in,
	input wire logic [31:0] branch_target_in,
	input wire logic        exc_return_in,
	input wire logic [31:0] stacked_word_in,
	input wire logic        insn_issue_in,
	input wire logic        xfer_interrupt_in,
	input wire logic [3:0]  xfer_next_reg_in,
	input wire logic        move_privileged_in,
	input wire logic [31:0] move_rdata_out,
	input wire logic [31:0] stack_word_out,
	input wire logic        exec_state_out,
	input wire logic        xfer_resume_out,
	input wire logic        state_fault_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	property p_vec; vector_valid_in |=> exec_state_out == $past(vector_value_in[0]); endproperty
	a_vec: assert property (p_vec) else $error("vector");
	property p_br; exch_branch_in && !vector_valid_in && !exc_return_in
		|=> exec_state_out == $past(branch_target_in[0]); endproperty
	a_br: assert property (p_br) else $error("branch");
	property p_ret; exc_return_in && !vector_valid_in
		|=> exec_state_out == $past(stacked_word_in[24]); endproperty
	a_ret: assert property (p_ret) else $error("return");
	property p_flt; !vector_valid_in
		|=> state_fault_out == ($past(insn_issue_in) && !$past(exec_state_out)); endproperty
	a_flt: assert property (p_flt) else $error("fault");
	property p_ici; xfer_interrupt_in && !vector_valid_in && !exc_return_in
		|=> xfer_resume_out && stack_word_out[15:12] == $past(xfer_next_reg_in); endproperty
	a_ici: assert property (p_ici) else $error("resume");
	property p_zero; xfer_resume_out
		|-> {stack_word_out[26:25], stack_word_out[11:10]} == 4'h0; endproperty
	a_zero: assert property (p_zero) else $error("resume zero");
	property p_rsv;
		{stack_word_out[23:16], stack_word_out[9:6], move_rdata_out[23:16]} == 20'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_app; !move_privileged_in
		|-> {move_rdata_out[26:24], move_rdata_out[15:10]} == 9'h0; endproperty
	a_app: assert property (p_app) else $error("app read");
endmodule : exec_state_chk
bind execution_state_status_bits exec_state_chk u_chk (.*);

// ---- tb/execution_state_status_bits_tb.sv ----
// Self-checking bench for the execution-state bits
`timescale 1ns/100ps
module execution_state_status_bits_tb;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [9:0] p = '0;
	logic [31:0] d = '0;
	logic [31:0] sw, rd, stk;
	logic st, act, rs, flt;
	logic [3:0] cnd, sr, r;
	logic [7:0] s;
	logic [31:0] seed = 32'h840eabf3;
	int err_count = 0;
	int checks_done = 0;
	always #4 clock_in = ~clock_in;
	stack_frame_model u_stk (.clock_in(clock_in), .rstn_in(rstn_in), .push_in(p[9]),
		.word_in(sw), .word_out(stk));
	execution_state_status_bits DUT (.clock_in(clock_in), .rstn_in(rstn_in),
		.vector_valid_in(p[9]), .vector_value_in(d), .exch_branch_in(p[8]),
		.branch_target_in(d), .exc_return_in(p[7]), .stacked_word_in(stk),
		.itb_start_in(p[6]), .itb_init_in(d[7:0]), .insn_retire_in(p[5]),
		.insn_issue_in(p[4]), .xfer_interrupt_in(p[3]), .xfer_next_reg_in(d[3:0]),
		.xfer_done_in(p[2]), .sat_set_in(p[1]), .move_write_in(p[0]),
		.move_privileged_in(d[10]), .move_view_in(d[9:8]), .move_wdata_in(d),
		.move_rdata_out(rd), .stack_word_out(sw), .exec_state_out(st), .itb_active_out(act),
		.itb_cond_out(cnd), .xfer_resume_out(rs), .xfer_start_reg_out(sr), .state_fault_out(flt));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Block state as placed in the word
	function automatic logic [31:0] fld(input logic [7:0] v);
		return {5'h0, v[1:0], 9'h0, v[7:2], 10'h0};
	endfunction : fld
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One request taken at the next edge
	task automatic go(input logic [9:0] q, input logic [31:0] v);
		@(posedge clock_in);
		p <= q;
		d <= v;
		@(posedge clock_in);
		p <= '0;
		#1;
	endtask : go
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// Cycle ceiling against a hang
	initial begin
		repeat (2000) @(posedge clock_in);
		err_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clock_in);
		rstn_in <= 1'b1;
		#1;
		chk("reset word", sw, 32'h01000000);
		for (int i = 0; i < 8; i++) begin
			s = (i == 0) ? 8'h18 : 8'(rnd());
			if (s[3:0] == 4'h0) s[0] = 1'b1;
			go(10'h040, {24'h0, s});
			for (int k = 0; k < 5; k++) begin
				chk("block field", sw & 32'h0600fc00, fld(s));
				chk("block active", act, s[3:0] != 4'h0);
				if (s[3:0] != 4'h0) chk("slot cond", cnd, s[7:4]);
				go(10'h020, 0);
				s = (s[3:0] == 4'h8) ? 8'h0 : {s[7:5], s[3:0], 1'b0};
			end
		end
		go(10'h100, 32'h1000);
		chk("branch state", st, 1'b0);
		go(10'h010, 0);
		chk("fault", flt, 1'b1);
		go(10'h200, 32'h1);
		chk("vector state", st, 1'b1);
		go(10'h010, 0);
		chk("no fault", flt, 1'b0);
		go(10'h080, 0);
		chk("return state", st, 1'b0);
		go(10'h200, 32'h1);
		r = 4'(rnd()) | 4'h1;
		go(10'h008, {28'h0, r});
		chk("resume word", sw & 32'h0600fc00, {16'h0, r, 12'h0});
		go(10'h200, 32'h1);
		go(10'h004, 0);
		go(10'h080, 0);
		chk("return resume", {rs, sr}, {1'b1, r});
		go(10'h004, 0);
		go(10'h042, 32'h18);
		repeat (4) go(10'h0, 32'h18);
		chk("sat held", sw[27], 1'b1);
		for (int v = 0; v < 8; v++) begin
			go(10'h0, {21'h0, v[2:0], 8'h18});
			chk("view read", rd & 32'h07ffffc0, v[2] && !v[1] ? 32'h01000000 | fld(8'h18) : 0);
		end
		go(10'h001, 32'hfffffcff);
		chk("write ignored", sw & 32'h07ffffc0, 32'h01000000 | fld(8'h18));
		go(10'h001, 32'h400);
		chk("sat cleared", sw[27], 1'b0);
		give_verdict();
	end
endmodule : execution_state_status_bits_tb

// ---- tb/stack_frame_model.sv ----
// Stack model keeping the status word saved on exception entry
`timescale 1ns/100ps
module stack_frame_model (
	input  wire logic        clock_in, // Core clock
	input  wire logic        rstn_in,  // Reset, active low
	input  wire logic        push_in,  // Exception entry
	input  wire logic [31:0] word_in,  // Word to stack
	output logic      [31:0] word_out  // Word popped on return
);
	// Frame kept whole, reserved bits included
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			word_out <= 32'h0;
		end else if (push_in) begin
			word_out <= word_in;
		end
	end
endmodule : stack_frame_model
